// ---- fod_params.svh ----
// offsets, field positions, codes and reset values of the fp opcode decoder
`ifndef FOD_PARAMS_SVH
`define FOD_PARAMS_SVH

// apb register byte addresses
`define FOD_ADDR_W 12
`define FOD_ADDR_STATUS 12'h000
`define FOD_ADDR_CONFIG 12'h004
`define FOD_ADDR_INSTR 12'h008
`define FOD_ADDR_RESULT 12'h00C
`define FOD_ADDR_REGMAP 12'h010

// system_status_reg image bits
`define FOD_SR_FR_BIT 26
`define FOD_SR_CU_BIT 29
`define FOD_SR_RESET 32'h00000000

// config register bits
`define FOD_CFG_FPU_BIT 0
`define FOD_CFG_DP_BIT 1
`define FOD_CFG_EXT_BIT 2
`define FOD_CFG_RESET 3'h7

// result register fields
`define FOD_RES_OP_LSB 0
`define FOD_RES_PRED_LSB 8
`define FOD_RES_INV_BIT 12
`define FOD_RES_EXC_LSB 16
`define FOD_RES_VALID_BIT 31

// regmap register fields
`define FOD_MAP_FS_LSB 0
`define FOD_MAP_FT_LSB 5
`define FOD_MAP_FD_LSB 10
`define FOD_MAP_SRC_PAIR_BIT 16
`define FOD_MAP_SRC_LOW_BIT 17
`define FOD_MAP_DST_PAIR_BIT 18
`define FOD_MAP_DST_NEXT_BIT 19
`define FOD_MAP_DST_UPPER_BIT 20
`define FOD_MAP_ODD_BIT 21

// sub-opcode groups in bits [25:24]
`define FOD_GRP_XFER 2'h0
`define FOD_GRP_BRANCH 2'h1
`define FOD_GRP_FMT 2'h2

// transfer selectors in bits [23:21]
`define FOD_XF_MOVE_FROM 3'h0
`define FOD_XF_DMOVE_FROM 3'h1
`define FOD_XF_CTRL_FROM 3'h2
`define FOD_XF_MOVE_TO 3'h4
`define FOD_XF_DMOVE_TO 3'h5
`define FOD_XF_CTRL_TO 3'h6

// format field codes
`define FOD_FMT_S 5'h10
`define FOD_FMT_D 5'h11
`define FOD_FMT_W 5'h14
`define FOD_FMT_L 5'h15

// function field groups and codes
`define FOD_FN_ARITH 3'h0
`define FOD_FN_ROUND 3'h1
`define FOD_FN_CVT 3'h4
`define FOD_FN_CONVERT_TO_SINGLE 6'h20
`define FOD_FN_CONVERT_TO_DOUBLE 6'h21
`define FOD_FN_CONVERT_TO_WORD_FIXED 6'h24
`define FOD_FN_CONVERT_TO_LONG_FIXED 6'h25

`endif

// ---- fod_pkg.sv ----
// types shared by the fp opcode decoder files
package fod_pkg;

  // operation handed to the datapath
  typedef enum logic [4:0] {
    FOD_OP_NONE = 5'h00,
    FOD_OP_ADD = 5'h01,
    FOD_OP_SUB = 5'h02,
    FOD_OP_MUL = 5'h03,
    FOD_OP_DIV = 5'h04,
    FOD_OP_SQRT = 5'h05,
    FOD_OP_ABS = 5'h06,
    FOD_OP_MOV = 5'h07,
    FOD_OP_NEG = 5'h08,
    FOD_OP_CVT_LONG_NEAREST = 5'h09,
    FOD_OP_CVT_LONG_TOWARD_ZERO = 5'h0A,
    FOD_OP_CVT_LONG_TOWARD_POS_INF = 5'h0B,
    FOD_OP_CVT_LONG_TOWARD_NEG_INF = 5'h0C,
    FOD_OP_CVT_WORD_NEAREST = 5'h0D,
    FOD_OP_CVT_WORD_TOWARD_ZERO = 5'h0E,
    FOD_OP_CVT_WORD_TOWARD_POS_INF = 5'h0F,
    FOD_OP_CVT_WORD_TOWARD_NEG_INF = 5'h10,
    FOD_OP_CONVERT_TO_SINGLE = 5'h11,
    FOD_OP_CONVERT_TO_DOUBLE = 5'h12,
    FOD_OP_CONVERT_TO_WORD_FIXED = 5'h13,
    FOD_OP_CONVERT_TO_LONG_FIXED = 5'h14,
    FOD_OP_COMPARE = 5'h15,
    FOD_OP_MOVE_FROM_FP = 5'h16,
    FOD_OP_DWORD_MOVE_FROM_FP = 5'h17,
    FOD_OP_MOVE_FROM_FP_CONTROL = 5'h18,
    FOD_OP_MOVE_TO_FP = 5'h19,
    FOD_OP_DWORD_MOVE_TO_FP = 5'h1A,
    FOD_OP_MOVE_TO_FP_CONTROL = 5'h1B,
    FOD_OP_FP_CONDITION_BRANCH = 5'h1C
  } fod_op_t;

  // exception raised by decode
  typedef enum logic [1:0] {
    FOD_EXC_NONE = 2'h0,
    FOD_EXC_COPROC_UNUSABLE = 2'h1,
    FOD_EXC_RESERVED_INSTR = 2'h2,
    FOD_EXC_UNIMPL_OP = 2'h3
  } fod_exc_t;

endpackage

// ---- fod_decode_core.sv ----
// combinational classifier of one coprocessor-1 instruction word
`include "fod_params.svh"

module fod_decode_core
  import fod_pkg::*;
#(
  parameter logic [31:0] TOP_RESERVED_MASK = 32'h00000000
)
(
  // instruction and mode inputs
  input wire logic [31:0] instr,
  input wire logic fpu_present,
  input wire logic cu_usable,
  input wire logic dp_present,
  input wire logic ext64_en,
  // classification
  output fod_op_t op,
  output logic [4:0] fmt_dst,
  output logic [3:0] pred,
  output logic inv_unord,
  output fod_exc_t exc
);

  logic [1:0] grp;
  logic [2:0] sel;
  logic [4:0] fmt;
  logic [5:0] fn;
  logic fmt_sd;
  logic uo;
  fod_op_t op_raw;

  assign grp = instr[25:24];
  assign sel = instr[23:21];
  assign fmt = instr[25:21];
  assign fn = instr[5:0];
  assign fmt_sd = (fmt == `FOD_FMT_S) || (fmt == `FOD_FMT_D);
  assign pred = fn[3:0];
  assign inv_unord = fn[3];

  // raw op plus unimplemented-op detection; exceptions are ranked afterwards
  always_comb
  begin
    op_raw = FOD_OP_NONE;
    uo = 1'b0;
    fmt_dst = fmt;
    case (grp)
      `FOD_GRP_XFER:
      begin
        case (sel)
          `FOD_XF_MOVE_FROM: op_raw = FOD_OP_MOVE_FROM_FP;
          `FOD_XF_DMOVE_FROM: op_raw = FOD_OP_DWORD_MOVE_FROM_FP;
          `FOD_XF_CTRL_FROM: op_raw = FOD_OP_MOVE_FROM_FP_CONTROL;
          `FOD_XF_MOVE_TO: op_raw = FOD_OP_MOVE_TO_FP;
          `FOD_XF_DMOVE_TO: op_raw = FOD_OP_DWORD_MOVE_TO_FP;
          `FOD_XF_CTRL_TO: op_raw = FOD_OP_MOVE_TO_FP_CONTROL;
          default: uo = 1'b1;
        endcase
        // doubleword transfers need the 64-bit extension and double hardware
        if (sel == `FOD_XF_DMOVE_FROM || sel == `FOD_XF_DMOVE_TO)
          uo = uo | ~ext64_en | ~dp_present;
      end
      `FOD_GRP_BRANCH:
      begin
        if (sel == 3'h0)
          op_raw = FOD_OP_FP_CONDITION_BRANCH;
        else
          uo = 1'b1;
      end
      `FOD_GRP_FMT:
      begin
        // format row: reserved formats, and D or L without the hardware
        uo = !(fmt == `FOD_FMT_S || fmt == `FOD_FMT_D || fmt == `FOD_FMT_W
               || fmt == `FOD_FMT_L);
        if (fmt == `FOD_FMT_D)
          uo = uo | ~dp_present;
        if (fmt == `FOD_FMT_L)
          uo = uo | ~ext64_en | ~dp_present;
        case (fn[5:3])
          `FOD_FN_ARITH:
          begin
            op_raw = fod_op_t'(5'(FOD_OP_ADD) + {2'h0, fn[2:0]});
            uo = uo | ~fmt_sd;
          end
          `FOD_FN_ROUND:
          begin
            // long targets in codes 8..11, word targets in 12..15
            op_raw = fod_op_t'(5'(FOD_OP_CVT_LONG_NEAREST) + {2'h0, fn[2:0]});
            fmt_dst = fn[2] ? `FOD_FMT_W : `FOD_FMT_L;
            uo = uo | ~fmt_sd;
            if (!fn[2])
              uo = uo | ~ext64_en | ~dp_present;
          end
          `FOD_FN_CVT:
          begin
            case (fn)
              `FOD_FN_CONVERT_TO_SINGLE:
              begin
                op_raw = FOD_OP_CONVERT_TO_SINGLE;
                fmt_dst = `FOD_FMT_S;
                uo = uo | (fmt == `FOD_FMT_S);
              end
              `FOD_FN_CONVERT_TO_DOUBLE:
              begin
                op_raw = FOD_OP_CONVERT_TO_DOUBLE;
                fmt_dst = `FOD_FMT_D;
                uo = uo | (fmt == `FOD_FMT_D) | ~dp_present;
              end
              `FOD_FN_CONVERT_TO_WORD_FIXED:
              begin
                op_raw = FOD_OP_CONVERT_TO_WORD_FIXED;
                fmt_dst = `FOD_FMT_W;
                uo = uo | ~fmt_sd;
              end
              `FOD_FN_CONVERT_TO_LONG_FIXED:
              begin
                op_raw = FOD_OP_CONVERT_TO_LONG_FIXED;
                fmt_dst = `FOD_FMT_L;
                uo = uo | ~fmt_sd | ~ext64_en | ~dp_present;
              end
              default: uo = 1'b1;
            endcase
          end
          3'h6, 3'h7:
          begin
            op_raw = FOD_OP_COMPARE;
            uo = uo | ~fmt_sd;
          end
          default: uo = 1'b1;
        endcase
      end
      default: uo = 1'b1;
    endcase
  end

  // ranking: unusable, then reserved, then unimplemented; any exception kills the op
  always_comb
  begin
    op = FOD_OP_NONE;
    if (!fpu_present || !cu_usable)
      exc = FOD_EXC_COPROC_UNUSABLE;
    else if (TOP_RESERVED_MASK[fmt])
      exc = FOD_EXC_RESERVED_INSTR;
    else if (uo)
      exc = FOD_EXC_UNIMPL_OP;
    else
    begin
      exc = FOD_EXC_NONE;
      op = op_raw;
    end
  end

endmodule

// ---- fod_decoder.sv ----
// apb-controlled fp opcode decoder with register-width operand mapping
//
// Decided for this implementation: the register offsets and the APB slave port.
`include "fod_params.svh"

// Notes on behaviour
// - function 0..7 are add, sub, mul, div, sqrt, abs, move, negate
// - function 8..11 convert to long with nearest, zero, plus, minus rounding
// - function 12..15 convert to word with nearest, zero, plus, minus rounding
// - function 32 converts to single, 33 converts to double
// - function 36 converts to word fixed, 37 to long fixed
// - function 48..63 are compares, low four bits pick the predicate
// - reserved function and sub-opcode codes raise unimplemented operation
// - sub-opcode splits into [25:24] and [23:21]; group zero selects transfers
// - width bit clear: only even registers valid, registers 32 bits wide
// - width bit set: odd and even registers usable, 64 bits wide
// - 32-bit mode: S/W read fpr, doubles read fpr+1 high, fpr low
// - 32-bit mode: S/W write fpr and spoil fpr+1; doubles fill both
// - 64-bit mode: single uses bits 31:0; S/W writes leave top undefined
// - ops needing the 64-bit extension fail when it is disabled
// - ops needing double hardware fail when it is absent
// - top-level reserved codes raise reserved instruction instead
// - without the coprocessor every fp instruction is coprocessor unusable
// - format 16, 17, 20, 21 are single, double, word, long
// - predicates 8..15 also trap invalid when operands are unordered
module fod_decoder
  import fod_pkg::*;
#(
  parameter int ADDR_W = `FOD_ADDR_W,
  parameter logic [31:0] TOP_RESERVED_MASK = 32'h00000000
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction issue from the integer pipeline
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  // decoded instruction towards the datapath
  output logic dec_valid,
  output fod_op_t dec_op,
  output logic [3:0] dec_pred,
  output logic dec_inv_unord,
  output fod_exc_t dec_exc,
  output logic [4:0] dec_fmt_dst,
  // operand and result register mapping
  output logic [4:0] dec_fs,
  output logic [4:0] dec_fs_hi,
  output logic [4:0] dec_ft,
  output logic [4:0] dec_ft_hi,
  output logic [4:0] dec_fd,
  output logic [4:0] dec_fd_hi,
  output logic dec_src_pair,
  output logic dec_src_low_only,
  output logic dec_dst_pair,
  output logic dec_dst_next_undef,
  output logic dec_dst_upper_undef,
  output logic dec_odd_undef
);

  // refused at elaboration: a narrower bus cannot reach every register
  if (ADDR_W < `FOD_ADDR_W)
  begin
    $error("fod_decoder: ADDR_W too small for the register map");
  end

  // whole state of the block
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sr_fr;
    logic sr_cu;
    logic cfg_fpu;
    logic cfg_dp;
    logic cfg_ext;
    logic [31:0] last_instr;
    logic dec_valid;
    fod_op_t op;
    logic [3:0] pred;
    logic inv_unord;
    fod_exc_t exc;
    logic [4:0] fmt_dst;
    logic [4:0] fs;
    logic [4:0] fs_hi;
    logic [4:0] ft;
    logic [4:0] ft_hi;
    logic [4:0] fd;
    logic [4:0] fd_hi;
    logic src_pair;
    logic src_low_only;
    logic dst_pair;
    logic dst_next_undef;
    logic dst_upper_undef;
    logic odd_undef;
  } fod_state_t;

  fod_state_t state_reg;
  fod_state_t state_next;

  // address decode shared by the read mux and the write path
  function automatic logic fod_addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    // address bits above the map must be zero too, so widen the offset
    fod_addr_hit = (a == ADDR_W'(off));
  endfunction

  function automatic logic fod_addr_mapped(input logic [ADDR_W-1:0] a);
    fod_addr_mapped = fod_addr_hit(a, `FOD_ADDR_STATUS) || fod_addr_hit(a, `FOD_ADDR_CONFIG)
      || fod_addr_hit(a, `FOD_ADDR_INSTR) || fod_addr_hit(a, `FOD_ADDR_RESULT)
      || fod_addr_hit(a, `FOD_ADDR_REGMAP);
  endfunction

  logic apb_setup;
  logic apb_commit;
  logic launch;
  logic [31:0] word;
  logic [4:0] w_fmt;
  logic two_word;
  logic one_word;
  fod_op_t core_op;
  logic [4:0] core_fmt_dst;
  logic [3:0] core_pred;
  logic core_inv;
  fod_exc_t core_exc;
  logic [31:0] rd_status;
  logic [31:0] rd_result;
  logic [31:0] rd_regmap;

  assign apb_setup = psel && !penable;
  assign apb_commit = psel && penable && state_reg.pready;

  // the pipeline port has priority; an apb write to the instruction
  // register in the same cycle is dropped rather than queued
  assign launch = instr_valid || (apb_commit && pwrite && fod_addr_hit(paddr, `FOD_ADDR_INSTR));
  assign word = instr_valid ? instr_word : pwdata;
  assign w_fmt = word[25:21];

  fod_decode_core #(
    .TOP_RESERVED_MASK(TOP_RESERVED_MASK)
  ) fod_decode_core_i (
    .instr(word),
    .fpu_present(state_reg.cfg_fpu),
    .cu_usable(state_reg.sr_cu),
    .dp_present(state_reg.cfg_dp),
    .ext64_en(state_reg.cfg_ext),
    .op(core_op),
    .fmt_dst(core_fmt_dst),
    .pred(core_pred),
    .inv_unord(core_inv),
    .exc(core_exc)
  );

  // operand width classes: doubles and longs span two 32-bit registers
  assign two_word = (w_fmt == `FOD_FMT_D) || (w_fmt == `FOD_FMT_L);
  assign one_word = (core_fmt_dst == `FOD_FMT_S) || (core_fmt_dst == `FOD_FMT_W);

  // read views of status, result and mapping
  always_comb
  begin
    rd_status = `FOD_SR_RESET;
    rd_status[`FOD_SR_FR_BIT] = state_reg.sr_fr;
    rd_status[`FOD_SR_CU_BIT] = state_reg.sr_cu;
    rd_result = 32'h00000000;
    rd_result[`FOD_RES_OP_LSB +: 5] = state_reg.op;
    rd_result[`FOD_RES_PRED_LSB +: 4] = state_reg.pred;
    rd_result[`FOD_RES_INV_BIT] = state_reg.inv_unord;
    rd_result[`FOD_RES_EXC_LSB +: 2] = state_reg.exc;
    rd_result[`FOD_RES_VALID_BIT] = state_reg.dec_valid;
    rd_regmap = 32'h00000000;
    rd_regmap[`FOD_MAP_FS_LSB +: 5] = state_reg.fs;
    rd_regmap[`FOD_MAP_FT_LSB +: 5] = state_reg.ft;
    rd_regmap[`FOD_MAP_FD_LSB +: 5] = state_reg.fd;
    rd_regmap[`FOD_MAP_SRC_PAIR_BIT] = state_reg.src_pair;
    rd_regmap[`FOD_MAP_SRC_LOW_BIT] = state_reg.src_low_only;
    rd_regmap[`FOD_MAP_DST_PAIR_BIT] = state_reg.dst_pair;
    rd_regmap[`FOD_MAP_DST_NEXT_BIT] = state_reg.dst_next_undef;
    rd_regmap[`FOD_MAP_DST_UPPER_BIT] = state_reg.dst_upper_undef;
    rd_regmap[`FOD_MAP_ODD_BIT] = state_reg.odd_undef;
  end

  // next-state logic: apb slave, configuration writes and one decode per launch
  always_comb
  begin
    state_next = state_reg;
    // one wait-free access phase: pready rises for the cycle after setup
    state_next.pready = apb_setup;
    state_next.pslverr = apb_setup && !fod_addr_mapped(paddr);
    if (apb_setup)
    begin
      if (fod_addr_hit(paddr, `FOD_ADDR_STATUS))
        state_next.prdata = rd_status;
      else if (fod_addr_hit(paddr, `FOD_ADDR_CONFIG))
        state_next.prdata = {29'h0, state_reg.cfg_ext, state_reg.cfg_dp, state_reg.cfg_fpu};
      else if (fod_addr_hit(paddr, `FOD_ADDR_INSTR))
        state_next.prdata = state_reg.last_instr;
      else if (fod_addr_hit(paddr, `FOD_ADDR_RESULT))
        state_next.prdata = rd_result;
      else if (fod_addr_hit(paddr, `FOD_ADDR_REGMAP))
        state_next.prdata = rd_regmap;
      else
        state_next.prdata = 32'h00000000;
    end
    if (apb_commit && pwrite)
    begin
      if (fod_addr_hit(paddr, `FOD_ADDR_STATUS))
      begin
        state_next.sr_fr = pwdata[`FOD_SR_FR_BIT];
        state_next.sr_cu = pwdata[`FOD_SR_CU_BIT];
      end
      if (fod_addr_hit(paddr, `FOD_ADDR_CONFIG))
      begin
        state_next.cfg_fpu = pwdata[`FOD_CFG_FPU_BIT];
        state_next.cfg_dp = pwdata[`FOD_CFG_DP_BIT];
        state_next.cfg_ext = pwdata[`FOD_CFG_EXT_BIT];
      end
    end
    // result outputs hold until the next launch; dec_valid is a pulse
    state_next.dec_valid = launch;
    if (launch)
    begin
      state_next.last_instr = word;
      state_next.op = core_op;
      state_next.exc = core_exc;
      state_next.pred = core_pred;
      state_next.inv_unord = core_inv;
      state_next.fmt_dst = core_fmt_dst;
      state_next.fs = word[15:11];
      state_next.ft = word[20:16];
      state_next.fd = word[10:6];
      // upper-half partners for 32-bit pairs; fpr+1 wraps inside 5 bits
      state_next.fs_hi = 5'(word[15:11] + 5'h01);
      state_next.ft_hi = 5'(word[20:16] + 5'h01);
      state_next.fd_hi = 5'(word[10:6] + 5'h01);
      if (!state_reg.sr_fr)
      begin
        // 32-bit registers, even numbers only
        state_next.src_pair = two_word;
        state_next.src_low_only = 1'b0;
        state_next.dst_pair = !one_word;
        state_next.dst_next_undef = one_word;
        state_next.dst_upper_undef = 1'b0;
        state_next.odd_undef = word[11] | word[16] | word[6];
      end
      else
      begin
        // 64-bit registers, every number usable
        state_next.src_pair = 1'b0;
        state_next.src_low_only = (w_fmt == `FOD_FMT_S);
        state_next.dst_pair = 1'b0;
        state_next.dst_next_undef = 1'b0;
        state_next.dst_upper_undef = one_word;
        state_next.odd_undef = 1'b0;
      end
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      state_reg.sr_fr <= 1'(`FOD_SR_RESET >> `FOD_SR_FR_BIT);
      state_reg.sr_cu <= 1'(`FOD_SR_RESET >> `FOD_SR_CU_BIT);
      state_reg.cfg_fpu <= 1'(`FOD_CFG_RESET >> `FOD_CFG_FPU_BIT);
      state_reg.cfg_dp <= 1'(`FOD_CFG_RESET >> `FOD_CFG_DP_BIT);
      state_reg.cfg_ext <= 1'(`FOD_CFG_RESET >> `FOD_CFG_EXT_BIT);
    end
    else
      state_reg <= state_next;
  end

  // outputs straight from the state register
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign dec_valid = state_reg.dec_valid;
  assign dec_op = state_reg.op;
  assign dec_pred = state_reg.pred;
  assign dec_inv_unord = state_reg.inv_unord;
  assign dec_exc = state_reg.exc;
  assign dec_fmt_dst = state_reg.fmt_dst;
  assign dec_fs = state_reg.fs;
  assign dec_fs_hi = state_reg.fs_hi;
  assign dec_ft = state_reg.ft;
  assign dec_ft_hi = state_reg.ft_hi;
  assign dec_fd = state_reg.fd;
  assign dec_fd_hi = state_reg.fd_hi;
  assign dec_src_pair = state_reg.src_pair;
  assign dec_src_low_only = state_reg.src_low_only;
  assign dec_dst_pair = state_reg.dst_pair;
  assign dec_dst_next_undef = state_reg.dst_next_undef;
  assign dec_dst_upper_undef = state_reg.dst_upper_undef;
  assign dec_odd_undef = state_reg.odd_undef;

  // checks on the decode path and the apb answer, all in the pclk domain
  default clocking fod_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic enabled;
  assign enabled = state_reg.cfg_fpu && state_reg.sr_cu && !TOP_RESERVED_MASK[w_fmt];

  no_fpu_cu_a: assert property (launch && !state_reg.cfg_fpu |=> dec_valid && dec_exc == FOD_EXC_COPROC_UNUSABLE)
    else $error("missing coprocessor did not give coprocessor unusable");
  top_rsvd_a: assert property (launch && state_reg.cfg_fpu && state_reg.sr_cu
    && TOP_RESERVED_MASK[w_fmt] |=> dec_exc == FOD_EXC_RESERVED_INSTR)
    else $error("top-level reserved code did not give reserved instruction");
  exc_no_op_a: assert property (dec_valid && dec_exc != FOD_EXC_NONE |-> dec_op == FOD_OP_NONE)
    else $error("excepted instruction still issued an operation");
  arith_map_a: assert property (launch && enabled && w_fmt == `FOD_FMT_S && word[5:3] == 3'h0
    |=> dec_op == fod_op_t'(5'(FOD_OP_ADD) + {2'h0, $past(word[2:0])}))
    else $error("arithmetic function mapped to wrong operation");
  round_long_a: assert property (launch && enabled && w_fmt == `FOD_FMT_S && word[5:0] == 6'h09
    && state_reg.cfg_ext && state_reg.cfg_dp |=> dec_op == FOD_OP_CVT_LONG_TOWARD_ZERO)
    else $error("function 9 is not long conversion toward zero");
  ext64_uo_a: assert property (launch && enabled && !state_reg.cfg_ext && w_fmt == `FOD_FMT_L
    |=> dec_exc == FOD_EXC_UNIMPL_OP)
    else $error("long format without extension not unimplemented");
  dp_uo_a: assert property (launch && enabled && !state_reg.cfg_dp && w_fmt == `FOD_FMT_D
    |=> dec_exc == FOD_EXC_UNIMPL_OP)
    else $error("double format without double hardware not unimplemented");
  rsvd_func_a: assert property (launch && enabled && w_fmt == `FOD_FMT_S && word[5:4] == 2'h1
    |=> dec_exc == FOD_EXC_UNIMPL_OP)
    else $error("reserved function 16..31 not unimplemented");
  cmp_invalid_a: assert property (dec_valid && dec_op == FOD_OP_COMPARE
    |-> dec_inv_unord == dec_pred[3] && $past(word[5:4]) == 2'h3)
    else $error("compare predicate signalling flag wrong");
  pair_read_a: assert property (launch && !state_reg.sr_fr && w_fmt == `FOD_FMT_D
    |=> dec_src_pair && dec_fs_hi == 5'(dec_fs + 5'h01))
    else $error("32-bit mode double source not read as pair");
  upper_undef_a: assert property (launch && state_reg.sr_fr && core_fmt_dst == `FOD_FMT_S
    |=> dec_dst_upper_undef && !dec_dst_pair && !dec_src_pair)
    else $error("64-bit mode single result did not mark upper half");
  apb_ready_a: assert property (apb_setup |=> pready ##1 !pready || (psel && !penable))
    else $error("apb answer did not come one cycle after setup");

endmodule

// ---- fod_issue_model.sv ----
// integer pipeline model issuing one coprocessor word per request
module fod_issue_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the bench
  input wire logic start,
  input wire logic [31:0] word_in,
  // issue port
  output logic instr_valid,
  output logic [31:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle word flips to its inverse every cycle so a stale word never passes for a fresh one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_valid <= 1'b0;
      instr_word <= 32'h00000000;
    end
    else
    begin
      instr_valid <= start;
      instr_word <= start ? word_in : ~instr_word;
    end
  end
endmodule

// ---- fod_decoder_tb_top.sv ----
// bench for the fp opcode decoder: apb and issue tasks with expected values
module fod_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fod_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, start, pready, pslverr, iv, dv, inv, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, iw, w, r;
  logic [3:0] pred;
  logic [4:0] fshi, fdst;
  wire logic [5:0] fl;
  logic [5:0] rsv [6] = '{6'h10, 6'h1F, 6'h22, 6'h23, 6'h26, 6'h2F};
  logic [2:0] xs [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  fod_op_t op;
  fod_exc_t exc;
  int failures, check_count, i;
  fod_issue_model fod_issue_model_i (.pclk(pclk), .presetn(presetn), .start(start),
    .word_in(w), .instr_valid(iv), .instr_word(iw));
  // format 19 also set as a top-level reserved code so the reserved path is reachable
  fod_decoder #(.TOP_RESERVED_MASK(32'h00080000)) fod_decoder_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(iv), .instr_word(iw), .dec_valid(dv), .dec_op(op),
    .dec_pred(pred), .dec_inv_unord(inv), .dec_exc(exc), .dec_fmt_dst(fdst), .dec_fs(),
    .dec_fs_hi(fshi), .dec_ft(), .dec_ft_hi(), .dec_fd(), .dec_fd_hi(),
    .dec_src_pair(fl[5]), .dec_src_low_only(fl[4]), .dec_dst_pair(fl[3]),
    .dec_dst_next_undef(fl[2]), .dec_dst_upper_undef(fl[1]), .dec_odd_undef(fl[0]));
  // 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1)
    begin
      failures++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // issue one word through the pipeline model, then compare exception and operation
  task dx(input logic [4:0] fmt, input logic [5:0] fn, input logic [4:0] fs,
    input fod_exc_t xe, input fod_op_t xo);
    int n;
    @(posedge pclk);
    w <= {6'h11, fmt, 5'h02, fs, 5'h04, fn};
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (dv !== 1'b1 && n < 6);
    if (dv !== 1'b1)
    begin
      failures++;
      end_sim();
    end
    chk(32'({exc, op}), 32'({xe, xo}));
  endtask
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, start} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    w = 32'h00000000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk(r, 32'h00000007);
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h00000000);
    dx(5'h10, 6'h00, 5'h0, FOD_EXC_COPROC_UNUSABLE, FOD_OP_NONE);
    apb(1'b1, 12'h000, 32'h20000000);
    for (i = 0; i < 16; i++)
      dx(5'h10, 6'(i), 5'h0, FOD_EXC_NONE, fod_op_t'(5'(i + 1)));
    dx(5'h14, 6'h20, 5'h0, FOD_EXC_NONE, FOD_OP_CONVERT_TO_SINGLE);
    chk(32'(fdst), 32'h00000010);
    dx(5'h14, 6'h21, 5'h0, FOD_EXC_NONE, FOD_OP_CONVERT_TO_DOUBLE);
    dx(5'h11, 6'h24, 5'h0, FOD_EXC_NONE, FOD_OP_CONVERT_TO_WORD_FIXED);
    dx(5'h11, 6'h25, 5'h0, FOD_EXC_NONE, FOD_OP_CONVERT_TO_LONG_FIXED);
    for (i = 48; i < 64; i++)
    begin
      dx(5'h10, 6'(i), 5'h0, FOD_EXC_NONE, FOD_OP_COMPARE);
      chk(32'({inv, pred}), 32'({i[3], i[3:0]}));
    end
    for (i = 0; i < 6; i++)
      dx(5'h10, rsv[i], 5'h0, FOD_EXC_UNIMPL_OP, FOD_OP_NONE);
    for (i = 0; i < 6; i++)
      dx({2'h0, xs[i]}, 6'h00, 5'h0, FOD_EXC_NONE, fod_op_t'(5'h16 + 5'(i)));
    dx(5'h12, 6'h00, 5'h0, FOD_EXC_UNIMPL_OP, FOD_OP_NONE);
    dx(5'h03, 6'h00, 5'h0, FOD_EXC_UNIMPL_OP, FOD_OP_NONE);
    // drop extension, double hardware, then the whole unit
    apb(1'b1, 12'h004, 32'h00000003);
    dx(5'h10, 6'h09, 5'h0, FOD_EXC_UNIMPL_OP, FOD_OP_NONE);
    apb(1'b1, 12'h004, 32'h00000005);
    dx(5'h11, 6'h00, 5'h0, FOD_EXC_UNIMPL_OP, FOD_OP_NONE);
    apb(1'b1, 12'h004, 32'h00000006);
    dx(5'h12, 6'h10, 5'h0, FOD_EXC_COPROC_UNUSABLE, FOD_OP_NONE);
    apb(1'b1, 12'h004, 32'h00000007);
    // register mapping in both width modes
    dx(5'h11, 6'h00, 5'h3, FOD_EXC_NONE, FOD_OP_ADD);
    chk(32'({fshi, fl}), 32'({5'h4, 6'b101001}));
    dx(5'h10, 6'h00, 5'h0, FOD_EXC_NONE, FOD_OP_ADD);
    chk(32'(fl), 32'(6'b000100));
    apb(1'b1, 12'h000, 32'h24000000);
    dx(5'h10, 6'h00, 5'h3, FOD_EXC_NONE, FOD_OP_ADD);
    chk(32'(fl), 32'(6'b010010));
    dx(5'h11, 6'h00, 5'h3, FOD_EXC_NONE, FOD_OP_ADD);
    chk(32'(fl), 32'(6'b000000));
    apb(1'b0, 12'h010, 32'h0);
    chk(r, 32'h00001043);
    dx(5'h13, 6'h00, 5'h0, FOD_EXC_RESERVED_INSTR, FOD_OP_NONE);
    // unmapped read, then a launch over the register bus
    apb(1'b0, 12'h020, 32'h0);
    chk({r[30:0], e}, 32'h00000001);
    apb(1'b1, 12'h008, 32'h46020100);
    apb(1'b0, 12'h00C, 32'h0);
    chk(r & 32'h0003001F, 32'h00000001);
    end_sim();
  end
endmodule
